// ---- hdl/afc_pkg.sv ----
/*
 * Shared constants for the AND-with-file and branch-on-carry execution block:
 * opcode patterns, field positions, addressing limits, sequencer states and reset values.
 * Assumes a 16-bit instruction word. Fields are placed as the opcode patterns give them.
 */
package afc_pkg;

   // ************************************************************
   // Opcode patterns and fields
   // ************************************************************
   localparam logic [15:0] OP_AND_MASK   = 16'hFC00;
   localparam logic [15:0] OP_AND_VALUE  = 16'h1400; // 0001 01da ffff ffff
   localparam logic [15:0] OP_BC_MASK    = 16'hFF00;
   localparam logic [15:0] OP_BC_VALUE   = 16'hE200; // 1110 0010 nnnn nnnn
   localparam int          DEST_BIT      = 9;
   localparam int          BANK_BIT      = 8;

   // ************************************************************
   // Addressing
   // ************************************************************
   localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;    // Highest indexed file address
   localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;    // Access bank low/high boundary
   localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;     // Bank of the access bank upper part

   // ************************************************************
   // Timing and reset values
   // ************************************************************
   localparam logic [1:0]  IDLE_QUARTERS = 2'h3;     // Last index of the idle cycle's quarters
   localparam logic [7:0]  RST_BYTE      = 8'h00;

   // ************************************************************
   // Sequencer states
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_Q1   = 3'b001,
      ST_Q2   = 3'b010,
      ST_Q3   = 3'b011,
      ST_Q4   = 3'b100,
      ST_NOP  = 3'b101
   } afc_state_t;

endpackage

// ---- hdl/afc_exec.sv ----
/*
 * Execution unit for AND-with-file and branch-on-carry-set, one instruction cycle
 * split into four quarter phases of sys_clk.
 * Assumes the fetch/decode sequencer drives all inputs on sys_clk, holds them while
 * instrValid is high, and that data memory answers a read in the cycle after memRdEn.
 */
// Summary of operation
// RULE1: Opcode 0001 01da ANDs accumulator with file register; only N and Z change.
// RULE2: Destination bit 0 writes the accumulator, 1 writes back to the file register.
// RULE3: Bank bit 0 uses the access bank, 1 uses the bank select register.
// RULE4: Bank bit 0 with extended set on: file address up to 95 is indexed.
// RULE5: Opcode 1110 0010 branches only when carry is set; no flags change.
// RULE6: Taken branch loads incremented PC plus twice the signed offset.
// RULE7: Taken branch takes two cycles, second idle; not taken takes one.
// RULE8: AND completes in one cycle: decode, read, process, write in quarter phases.
`timescale 1ns/1ps
module afc_exec
#(
   parameter int PC_W   = 21,
   parameter int ADDR_W = 12
)
(
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   input  wire logic              clkEn,
   input  wire logic              instrValid,
   input  wire logic [15:0]       instrWord,
   input  wire logic [7:0]        accIn,
   input  wire logic              carryIn,
   input  wire logic [ADDR_W-9:0] bankSelIn,
   input  wire logic              extEnable,
   input  wire logic [ADDR_W-1:0] indexBase,
   input  wire logic [PC_W-1:0]   pcIn,
   input  wire logic [7:0]        memRdData,
   output logic [ADDR_W-1:0]      memAddr,
   output logic                   memRdEn,
   output logic                   memWrEn,
   output logic [7:0]             wrData,
   output logic                   accWrEn,
   output logic                   flagWrEn,
   output logic                   negFlag,
   output logic                   zeroFlag,
   output logic                   pcWrEn,
   output logic [PC_W-1:0]        pcWrData,
   output logic                   indexedMode,
   output logic                   busy,
   output logic                   done,
   output logic                   unknownOp
);
   import afc_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      afc_state_t        st;
      logic [1:0]        nopCnt;
      logic [15:0]       op;
      logic [7:0]        acc;
      logic              carry;
      logic [ADDR_W-9:0] bankSel;
      logic              ext;
      logic [ADDR_W-1:0] base;
      logic [PC_W-1:0]   pc;
      logic [ADDR_W-1:0] memAddr;
      logic              memRdEn;
      logic              memWrEn;
      logic [7:0]        wrData;
      logic              accWrEn;
      logic              flagWrEn;
      logic              negFlag;
      logic              zeroFlag;
      logic              pcWrEn;
      logic [PC_W-1:0]   pcWrData;
      logic              indexed;
      logic              busy;
      logic              done;
      logic              unknown;
   } afc_regs_t;

   afc_regs_t state_r;
   afc_regs_t state_nxt;

   logic              isAnd;
   logic              isBranch;
   logic [7:0]        fileAddr;
   logic [7:0]        andRes;
   logic [PC_W-1:0]   offset2;

   // Decode of the held instruction
   assign isAnd    = (state_r.op & OP_AND_MASK) == OP_AND_VALUE;   // see RULE1
   assign isBranch = (state_r.op & OP_BC_MASK) == OP_BC_VALUE;     // see RULE5
   assign fileAddr = state_r.op[7:0];
   assign andRes   = state_r.acc & memRdData;                      // see RULE1
   assign offset2  = {{(PC_W-9){state_r.op[7]}}, state_r.op[7:0], 1'b0}; // see RULE6

   // ************************************************************
   // Quarter-phase sequencer
   // ************************************************************
   always_comb
   begin
      state_nxt = state_r;
      if (clkEn)
      begin
         state_nxt.memRdEn  = 1'b0;
         state_nxt.memWrEn  = 1'b0;
         state_nxt.accWrEn  = 1'b0;
         state_nxt.flagWrEn = 1'b0;
         state_nxt.pcWrEn   = 1'b0;
         state_nxt.done     = 1'b0;
         state_nxt.unknown  = 1'b0;
         case (state_r.st)
            ST_IDLE:
            begin
               if (instrValid)
               begin
                  state_nxt.st      = ST_Q1;
                  state_nxt.op      = instrWord;
                  state_nxt.acc     = accIn;
                  state_nxt.carry   = carryIn;
                  state_nxt.bankSel = bankSelIn;
                  state_nxt.ext     = extEnable;
                  state_nxt.base    = indexBase;
                  state_nxt.pc      = pcIn;
                  state_nxt.busy    = 1'b1;
               end
            end
            // Q1 decode and form the file address
            ST_Q1:
            begin
               state_nxt.st      = ST_Q2;
               state_nxt.indexed = 1'b0;
               if (isAnd)
               begin
                  state_nxt.memRdEn = 1'b1;
                  if (state_r.op[BANK_BIT])
                  begin
                     state_nxt.memAddr = {state_r.bankSel, fileAddr};  // see RULE3
                  end
                  else if (state_r.ext && fileAddr <= INDEX_LIMIT)
                  begin
                     state_nxt.memAddr = state_r.base +
                        {{(ADDR_W-8){1'b0}}, fileAddr};                 // see RULE4
                     state_nxt.indexed = 1'b1;
                  end
                  else if (fileAddr < ACCESS_SPLIT)
                  begin
                     state_nxt.memAddr = {{(ADDR_W-8){1'b0}}, fileAddr}; // see RULE3
                  end
                  else
                  begin
                     state_nxt.memAddr = {{(ADDR_W-12){1'b1}}, ACCESS_HI_BNK, fileAddr};
                  end
               end
               else if (!isBranch)
               begin
                  state_nxt.unknown = 1'b1; // Not handled here, let the sequencer know
               end
            end
            // Q2 read strobe is on the outputs during this quarter
            ST_Q2:
            begin
               state_nxt.st = ST_Q3;
            end
            // Q3 process data, raise the Q4 write strobes
            ST_Q3:
            begin
               state_nxt.st = ST_Q4;
               if (isAnd)
               begin
                  state_nxt.wrData   = andRes;
                  state_nxt.negFlag  = andRes[7];          // see RULE1
                  state_nxt.zeroFlag = andRes == RST_BYTE; // see RULE1
                  state_nxt.flagWrEn = 1'b1;
                  state_nxt.memWrEn  = state_r.op[DEST_BIT];  // see RULE2
                  state_nxt.accWrEn  = !state_r.op[DEST_BIT]; // see RULE2
               end
               else if (isBranch && state_r.carry)
               begin
                  state_nxt.pcWrData = state_r.pc + offset2; // see RULE6
                  state_nxt.pcWrEn   = 1'b1;                 // see RULE5
               end
            end
            // Q4 write; taken branch adds one idle instruction cycle
            ST_Q4:
            begin
               if (isBranch && state_r.carry)
               begin
                  state_nxt.st     = ST_NOP; // see RULE7
                  state_nxt.nopCnt = 2'h0;
               end
               else
               begin
                  state_nxt.st   = ST_IDLE;  // see RULE8
                  state_nxt.busy = 1'b0;
                  state_nxt.done = 1'b1;
               end
            end
            ST_NOP:
            begin
               state_nxt.nopCnt = state_r.nopCnt + 2'h1;
               if (state_r.nopCnt == IDLE_QUARTERS)
               begin
                  state_nxt.st   = ST_IDLE;  // see RULE7
                  state_nxt.busy = 1'b0;
                  state_nxt.done = 1'b1;
               end
            end
            default:
            begin
               state_nxt.st   = ST_IDLE;
               state_nxt.busy = 1'b0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Outputs straight from the state register
   assign memAddr     = state_r.memAddr;
   assign memRdEn     = state_r.memRdEn;
   assign memWrEn     = state_r.memWrEn;
   assign wrData      = state_r.wrData;
   assign accWrEn     = state_r.accWrEn;
   assign flagWrEn    = state_r.flagWrEn;
   assign negFlag     = state_r.negFlag;
   assign zeroFlag    = state_r.zeroFlag;
   assign pcWrEn      = state_r.pcWrEn;
   assign pcWrData    = state_r.pcWrData;
   assign indexedMode = state_r.indexed;
   assign busy        = state_r.busy;
   assign done        = state_r.done;
   assign unknownOp   = state_r.unknown;

   // ************************************************************
   // Checks
   // ************************************************************
   and_result_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RULE1
      state_r.st == ST_Q3 && isAnd && clkEn |=>
         wrData == ($past(state_r.acc) & $past(memRdData)) && flagWrEn)
      else $error("AND result or flag strobe wrong");

   and_flags_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RULE1
      flagWrEn |-> zeroFlag == (wrData == 8'h00) && negFlag == wrData[7] && isAnd)
      else $error("N or Z flag does not match result");

   dest_select_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RULE2
      (memWrEn || accWrEn) |->
         (memWrEn != accWrEn) && memWrEn == state_r.op[DEST_BIT] && state_r.st == ST_Q4)
      else $error("Destination write strobe wrong");

   bank_addr_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RULE3
      memRdEn && state_r.op[BANK_BIT] |-> memAddr == {state_r.bankSel, fileAddr}
         && !indexedMode)
      else $error("Banked address wrong");

   index_addr_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RULE4
      memRdEn && !state_r.op[BANK_BIT] && state_r.ext && fileAddr <= INDEX_LIMIT |->
         indexedMode && memAddr == state_r.base + {{(ADDR_W-8){1'b0}}, fileAddr})
      else $error("Indexed address wrong");

   branch_cond_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RULE5
      pcWrEn |-> isBranch && state_r.carry && !flagWrEn)
      else $error("PC written without carry branch");

   branch_target_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RULE6
      pcWrEn |-> PC_W'(pcWrData - state_r.pc) ==
         PC_W'({state_r.op[7:0], 1'b0}) - (state_r.op[7] ? PC_W'(512) : PC_W'(0)))
      else $error("Branch target wrong");

   taken_idle_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RULE7
      pcWrEn && clkEn ##1 clkEn [*4] |-> (busy && !done) ##1 done)
      else $error("Taken branch idle cycle wrong");

   one_cycle_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RULE8
      state_r.st == ST_IDLE && instrValid && clkEn ##1 clkEn [*4] ##0 !pcWrEn
         |=> done)
      else $error("Instruction did not finish in one cycle");

endmodule

// ---- verification/afc_mem_model.sv ----
/*
 * Data memory model facing the AND-with-file and branch-on-carry execution unit.
 * Assumes one sys_clk domain; read data is ready in the cycle after memRdEn.
 */
`timescale 1ns/1ps
module afc_mem_model
(
   input  wire logic        sys_clk,
   input  wire logic [11:0] memAddr,
   input  wire logic        memRdEn,
   input  wire logic        memWrEn,
   input  wire logic [7:0]  wrData,
   output logic [7:0]       memRdData
);
   // ************************************************************
   // Storage and read port
   // ************************************************************
   logic [7:0] memArr [0:4095];
   logic [7:0] rdData_r = 8'h00;

   assign memRdData = rdData_r;

   // One-cycle read, then data inverts every cycle without memRdEn so stale values do not hold steady
   always @(posedge sys_clk)
   begin
      if (memRdEn)
         rdData_r <= memArr[memAddr];
      else
         rdData_r <= ~rdData_r;
      if (memWrEn)
         memArr[memAddr] <= wrData;
   end
endmodule

// ---- verification/tb_afc_exec.sv ----
/*
 * Self-checking bench for the AND-with-file and branch-on-carry execution unit.
 * Assumes the data memory model beside it; inputs change 1 ns after the rising edge.
 */
`timescale 1ns/1ps
module tb_afc_exec;
   import afc_pkg::*;
   // ************************************************************
   // Stimulus signals and bookkeeping
   // ************************************************************
   logic sys_clk = 1'b0, arst_n = 1'b0, instrValid = 1'b0, carryIn = 1'b0, extEnable = 1'b0;
   logic [15:0] instrWord = 16'h0000;
   logic [7:0]  accIn = 8'h00, memRdData, wrData;
   logic [3:0]  bankSelIn = 4'h0;
   logic [11:0] indexBase = 12'h000, memAddr, rdAddr;
   logic [20:0] pcIn = 21'h000000, pcWrData;
   logic memRdEn, memWrEn, accWrEn, flagWrEn, negFlag, zeroFlag, pcWrEn, indexedMode, busy, done;
   int failCount = 0, nChecks = 0, nRd, nMw, nAw, nFw, nPw, doneAt;
   int nBy, nUk, stall = 0;
   logic clkEn = 1'b1, unknownOp;

   always #20 sys_clk = ~sys_clk;

   afc_exec uut (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .instrValid(instrValid),
      .instrWord(instrWord), .accIn(accIn), .carryIn(carryIn), .bankSelIn(bankSelIn),
      .extEnable(extEnable), .indexBase(indexBase), .pcIn(pcIn), .memRdData(memRdData),
      .memAddr(memAddr), .memRdEn(memRdEn), .memWrEn(memWrEn), .wrData(wrData),
      .accWrEn(accWrEn), .flagWrEn(flagWrEn), .negFlag(negFlag), .zeroFlag(zeroFlag),
      .pcWrEn(pcWrEn), .pcWrData(pcWrData), .indexedMode(indexedMode), .busy(busy),
      .done(done), .unknownOp(unknownOp));

   afc_mem_model mdl (.sys_clk(sys_clk), .memAddr(memAddr), .memRdEn(memRdEn),
      .memWrEn(memWrEn), .wrData(wrData), .memRdData(memRdData));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         failCount++;
         $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
      end
   endtask

   task automatic testDone();
      $display("checks %0d, mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // AND-with-file word from destination, bank and file address
   function automatic logic [15:0] andOp(input logic d, input logic a, input logic [7:0] f);
      return OP_AND_VALUE | (16'(d) << DEST_BIT) | (16'(a) << BANK_BIT) | 16'(f);
   endfunction

   // Issue one word, then count strobes until done, in cycles after accept
   task automatic run(input logic [15:0] w, input logic [7:0] acc, input logic c,
      input logic [3:0] bank_select_register, input logic e, input logic [11:0] base, input logic [20:0] pc);
      int k;
      nRd = 0; nMw = 0; nAw = 0; nFw = 0; nPw = 0; doneAt = -1;
      nBy = 0; nUk = 0;
      instrWord = w; accIn = acc; carryIn = c; bankSelIn = bank_select_register; extEnable = e;
      indexBase = base; pcIn = pc; instrValid = 1'b1;
      @(posedge sys_clk);
      #1 instrValid = 1'b0;
      // Optional freeze right after accept; the design must not move meanwhile
      if (stall > 0)
      begin
         clkEn = 1'b0;
         repeat (stall) @(posedge sys_clk);
         #1 clkEn = 1'b1;
      end
      for (k = 0; k < 14 && doneAt < 0; k++)
      begin
         if (memRdEn === 1'b1)
         begin
            nRd++;
            rdAddr = memAddr;
         end
         nMw += int'(memWrEn === 1'b1);
         nAw += int'(accWrEn === 1'b1);
         nFw += int'(flagWrEn === 1'b1);
         nPw += int'(pcWrEn === 1'b1);
         nUk += int'(unknownOp === 1'b1);
         nBy += int'(busy === 1'b1);
         if (done === 1'b1)
            doneAt = k + 1; // Accept edge is cycle 0, first quarter is cycle 1
         else
         begin
            @(posedge sys_clk);
            #1;
         end
      end
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic test_and_acc();
      mdl.memArr[12'h020] = 8'hC2;
      run(andOp(1'b0, 1'b0, 8'h20), 8'h17, 1'b1, 4'h3, 1'b0, 12'h000, 21'h0);
      chk("rdAddr", rdAddr, 12'h020);
      chk("wrData", wrData, 8'h02);
      chk("accWr", nAw, 1);
      chk("memWr", nMw, 0);
      chk("file", mdl.memArr[12'h020], 8'hC2);
      chk("nz", {negFlag, zeroFlag, 30'(nFw)}, {2'b00, 30'd1});
      chk("pcWr", nPw, 0);
      chk("doneAt", doneAt, 5);
      chk("indexed", indexedMode, 1'b0);
      chk("busy", nBy, 4);
      $display("test_and_acc finished");
   endtask

   task automatic test_and_bank();
      mdl.memArr[12'h380] = 8'hC2;
      run(andOp(1'b1, 1'b1, 8'h80), 8'h80, 1'b0, 4'h3, 1'b1, 12'h100, 21'h0);
      chk("rdAddr", rdAddr, 12'h380);
      chk("file", mdl.memArr[12'h380], 8'h80);
      chk("memWr", nMw, 1);
      chk("accWr", nAw, 0);
      chk("rdCount", nRd, 1);
      chk("nz", {negFlag, zeroFlag, indexedMode}, 3'b100);
      chk("doneAt", doneAt, 5);
      $display("test_and_bank finished");
   endtask

   task automatic test_access_modes();
      mdl.memArr[12'hF60] = 8'hF0;
      mdl.memArr[12'h15F] = 8'h3C;
      run(andOp(1'b0, 1'b0, ACCESS_SPLIT), 8'h0F, 1'b0, 4'h3, 1'b1, 12'h100, 21'h0);
      chk("rdAddr", rdAddr, 12'hF60);
      chk("nzi", {negFlag, zeroFlag, indexedMode}, 3'b010);
      run(andOp(1'b1, 1'b0, INDEX_LIMIT), 8'hFF, 1'b0, 4'h3, 1'b1, 12'h100, 21'h0);
      chk("rdAddr", rdAddr, 12'h15F);
      chk("indexed", indexedMode, 1'b1);
      chk("wrData", wrData, 8'h3C);
      $display("test_access_modes finished");
   endtask

   task automatic test_branch();
      run(OP_BC_VALUE | 16'h0080, 8'h00, 1'b1, 4'h0, 1'b0, 12'h000, 21'h01000);
      chk("target", pcWrData, 21'h00F00);
      chk("pcWr", nPw, 1);
      chk("flagWr", nFw, 0);
      chk("rdCount", nRd, 0);
      chk("memWr", nMw, 0);
      chk("accWr", nAw, 0);
      chk("doneAt", doneAt, 9);
      chk("busy", nBy, 8);
      run(OP_BC_VALUE | 16'h007F, 8'h00, 1'b1, 4'h0, 1'b0, 12'h000, 21'h01000);
      chk("target", pcWrData, 21'h010FE);
      chk("doneAt", doneAt, 9);
      run(OP_BC_VALUE | 16'h0010, 8'h00, 1'b0, 4'h0, 1'b0, 12'h000, 21'h02000);
      chk("pcWr", nPw, 0);
      chk("flagWr", nFw, 0);
      chk("doneAt", doneAt, 5);
      $display("test_branch finished");
   endtask

   task automatic test_unknown();
      run(16'hE600, 8'hFF, 1'b1, 4'h0, 1'b0, 12'h000, 21'h03000);
      chk("unknown", nUk, 1);
      chk("pcWr", nPw, 0);
      chk("doneAt", doneAt, 5);
      run(16'h1800, 8'hFF, 1'b0, 4'h0, 1'b0, 12'h000, 21'h03000);
      chk("unknown", nUk, 1);
      chk("rdCount", nRd, 0);
      chk("flagWr", nFw, 0);
      chk("doneAt", doneAt, 5);
      $display("test_unknown finished");
   endtask

   task automatic test_freeze();
      mdl.memArr[12'h345] = 8'h5A;
      stall = 3;
      run(andOp(1'b0, 1'b1, 8'h45), 8'h0F, 1'b0, 4'h3, 1'b0, 12'h000, 21'h0);
      stall = 0;
      chk("rdAddr", rdAddr, 12'h345);
      chk("wrData", wrData, 8'h0A);
      chk("accWr", nAw, 1);
      chk("doneAt", doneAt, 5);
      $display("test_freeze finished");
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial
   begin
      repeat (6) @(posedge sys_clk);
      #1 arst_n = 1'b1;
      test_and_acc();
      test_and_bank();
      test_access_modes();
      test_branch();
      test_unknown();
      test_freeze();
      testDone();
   end

   initial
   begin
      #(40 * 2000);
      failCount++;
      testDone();
   end
endmodule
